// ---- hw/timer_irq_control_port.sv ----
// 8-bit down-counting timer with prescaler, reload register and control port
// assumes the cpu core gives one-cycle port strobes synchronous to sys_clk
// Function
// - timer is an 8-bit down counter in interval, pulse-width or event mode
// - control port write sets enables, polarity, run, mode and prescale bits
// - control port read gives zeros in bits 0-6, event pin level in bit 7
// - phase clock runs at half the time base rate
// - prescale bits divide by 2, 5, 20 and multiply when combined
// - prescaler clears on stop, timer port write, pulse-width trailing edge
// - timer port write loads counter and reload, clears prescaler and request
// - prescaler clocks counter except in event mode; reload serves every mode
// - interval mode when bit 4 clear and some prescale bit set
// - counter reloads after 01 and sets request; 00 gives 256 counts
// - request reaches cpu only while bit 1 set; latch holds meanwhile
// - request latch clears only on acknowledge or reload write
// - timer port read returns live count without disturbing it
// - clearing run freezes count; restart resumes with prescaler at zero
// - interval spans 2 to 51,200 phase clock periods
// - bit 2 sets event pin active level: zero low, one high
// - pulse-width when bit 4 and a prescale bit set; event when all prescale bits clear
`timescale 1ns/1ps
`include "timer_irq_map.svh"
module timer_irq_control_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // cpu port access
  input wire timer_irq_pkg::port_req_s port_req,
  input wire logic timer_ack,
  // external pin
  input wire logic external_event_pin,
  // outputs
  output logic [7:0] read_data,
  output logic timer_irq,
  output logic [7:0] control_out
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] control;
  logic [7:0] count;
  logic [7:0] reload;
  logic [7:0] presc;
  logic phase;
  logic req_latch;
  logic pin_active_q;
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // divisor product of the three prescale bits
  function automatic logic [7:0] divisor(input logic [2:0] sel);
    unique case (sel)
      3'h1: divisor = `DIV_2;
      3'h2: divisor = `DIV_5;
      3'h3: divisor = `DIV_10;
      3'h4: divisor = `DIV_20;
      3'h5: divisor = `DIV_40;
      3'h6: divisor = `DIV_100;
      3'h7: divisor = `DIV_200;
      default: divisor = `DIV_2;
    endcase
  endfunction
  wire logic [2:0] presc_sel = control[`BIT_DIV20:`BIT_DIV2];
  wire logic [7:0] presc_div = divisor(presc_sel);
  wire logic any_presc = |presc_sel;
  wire timer_irq_pkg::timer_mode_e mode =
    !any_presc ? timer_irq_pkg::mode_event :
    control[`BIT_PWIDTH] ? timer_irq_pkg::mode_pulse_width : timer_irq_pkg::mode_interval;
  // one decode of strobe and address, shared by the four port selects
  function automatic logic port_hit(input logic strobe, input logic [3:0] addr,
                                    input logic [3:0] port);
    port_hit = strobe && addr == port;
  endfunction
  wire logic wr_ctrl = port_hit(port_req.wr, port_req.addr, `PORT_CONTROL);
  wire logic wr_timer = port_hit(port_req.wr, port_req.addr, `PORT_TIMER);
  wire logic rd_ctrl = port_hit(port_req.rd, port_req.addr, `PORT_CONTROL);
  wire logic rd_timer = port_hit(port_req.rd, port_req.addr, `PORT_TIMER);
  wire logic pin_active = external_event_pin ~^ control[`BIT_POLARITY];
  wire logic running = control[`BIT_RUN];
  wire logic pw_mode = mode == timer_irq_pkg::mode_pulse_width;
  wire logic ev_mode = mode == timer_irq_pkg::mode_event;
  // pulse width counts only while pin active; trailing edge clears prescaler
  wire logic pw_gate = !pw_mode || pin_active;
  wire logic trailing = pw_mode && pin_active_q && !pin_active;
  wire logic leading = pin_active && !pin_active_q;
  wire logic presc_clear = !running || wr_timer || trailing || !pw_gate;
  // wrap at or beyond divisor minus one, so a smaller divisor written mid-count
  // cannot let the prescaler run round all 256 states
  wire logic presc_wrap = presc >= presc_div - `PRESC_ONE;
  // counter tick source, prescaler bypassed in event mode
  wire logic presc_tick = phase && running && pw_gate && !ev_mode && presc_wrap;
  wire logic ev_tick = phase && running && ev_mode && leading;
  wire logic tick = presc_tick || ev_tick;
  // terminal count reloads and sets request
  wire logic terminal = tick && count == `COUNT_ONE;
  wire logic [7:0] next_count = terminal ? reload : count - `COUNT_ONE;
  // ----------------------------------------------------------------
  // phase clock enable
  // ----------------------------------------------------------------
  // phase strobe every second sys_clk edge stands in for the phase clock
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      phase <= 1'b0;
    end else begin
      phase <= !phase;
    end
  end
  // ----------------------------------------------------------------
  // control port
  // ----------------------------------------------------------------
  // control written from the accumulator
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      control <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      control <= port_req.data;
    end
  end
  // ----------------------------------------------------------------
  // prescaler and counter
  // ----------------------------------------------------------------
  // prescaler counts phase periods up to the divisor
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      presc <= `PRESC_ZERO;
    end else if (presc_clear || ev_mode) begin
      presc <= `PRESC_ZERO;
    end else if (phase) begin
      presc <= presc_wrap ? `PRESC_ZERO : presc + `PRESC_ONE;
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count <= `TIMER_RESET;
      reload <= `TIMER_RESET;
    end else if (wr_timer) begin
      count <= port_req.data;
      reload <= port_req.data;
    end else if (tick) begin
      count <= next_count;
    end
  end
  // pin history for edge detection, sampled on the phase strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_active_q <= 1'b0;
    end else if (phase) begin
      pin_active_q <= pin_active;
    end
  end
  // ----------------------------------------------------------------
  // request latch
  // ----------------------------------------------------------------
  // set wins over acknowledge, but a timer port write in the same cycle drops the terminal count
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      req_latch <= 1'b0;
    end else if (terminal && !wr_timer) begin
      req_latch <= 1'b1;
    end else if (timer_ack || wr_timer) begin
      req_latch <= 1'b0;
    end
  end
  // forwarded level, gated by timer enable
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= (req_latch || (terminal && !wr_timer)) && control[`BIT_TMR_EN];
    end
  end
  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // control read shows pin level; timer read shows live count
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      read_data <= `TIMER_RESET;
    end else if (rd_ctrl) begin
      read_data <= {external_event_pin, `READ_ZERO_LOW};
    end else if (rd_timer) begin
      read_data <= count;
    end
  end
  // control copy for the neighbouring interrupt logic
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      control_out <= `CTRL_RESET;
    end else begin
      control_out <= wr_ctrl ? port_req.data : control;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // span helper: phase periods since the last request
  // cleared whenever interval timing is broken off, so only whole intervals count
  logic [15:0] span;
  wire logic span_clear = terminal || wr_timer || !running ||
    mode != timer_irq_pkg::mode_interval;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      span <= `SPAN_ZERO;
    end else if (span_clear) begin
      span <= `SPAN_ZERO;
    end else if (phase) begin
      span <= span + `SPAN_ONE;
    end
  end
  AST_READ_CTRL: assert property (@(posedge sys_clk) disable iff (reset)
    rd_ctrl |=> read_data[6:0] == `READ_ZERO_LOW && read_data[7] == $past(external_event_pin))
    else $error("control read not pin level");
  AST_READ_TIMER: assert property (@(posedge sys_clk) disable iff (reset)
    rd_timer && !rd_ctrl |=> read_data == $past(count))
    else $error("timer read wrong");
  AST_LOAD: assert property (@(posedge sys_clk) disable iff (reset)
    wr_timer |=> count == $past(port_req.data) && reload == count &&
      presc == `PRESC_ZERO && !req_latch)
    else $error("timer load wrong");
  AST_FREEZE: assert property (@(posedge sys_clk) disable iff (reset)
    !running && !wr_timer |=> count == $past(count))
    else $error("counter moved while stopped");
  AST_RELOAD: assert property (@(posedge sys_clk) disable iff (reset)
    terminal && !wr_timer |=> count == reload && req_latch)
    else $error("terminal reload wrong");
  AST_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
    req_latch && !timer_ack && !wr_timer |=> req_latch)
    else $error("latch dropped");
  AST_FORWARD: assert property (@(posedge sys_clk) disable iff (reset)
    timer_irq |-> $past(control[`BIT_TMR_EN]))
    else $error("request forwarded while disabled");
  // prescaler within divisor, two cycles of grace after a divisor change
  AST_PRESC: assert property (@(posedge sys_clk) disable iff (reset)
    presc < presc_div || ev_mode || $past(wr_ctrl) || $past(wr_ctrl, 2))
    else $error("prescaler beyond divisor");
  AST_EVENT: assert property (@(posedge sys_clk) disable iff (reset)
    ev_mode && $past(ev_mode) |-> presc == `PRESC_ZERO)
    else $error("prescaler used in event mode");
  AST_PHASE: assert property (@(posedge sys_clk) disable iff (reset)
    1'b1 |=> phase != $past(phase))
    else $error("phase strobe stuck");
  AST_TICK_PHASE: assert property (@(posedge sys_clk) disable iff (reset)
    tick |-> phase)
    else $error("count step off the phase strobe");
  AST_STOP_CLEAR: assert property (@(posedge sys_clk) disable iff (reset)
    !running |=> presc == `PRESC_ZERO)
    else $error("prescaler kept while stopped");
  AST_TRAIL_CLEAR: assert property (@(posedge sys_clk) disable iff (reset)
    trailing |=> presc == `PRESC_ZERO)
    else $error("prescaler kept after trailing edge");
  AST_PW_HALT: assert property (@(posedge sys_clk) disable iff (reset)
    pw_mode && !pin_active && !wr_timer |=> count == $past(count))
    else $error("counted while pin inactive");
  AST_DOWN: assert property (@(posedge sys_clk) disable iff (reset)
    tick && !terminal && !wr_timer |=> count == $past(count) - `COUNT_ONE)
    else $error("count step not down by one");
  AST_MODE_INTERVAL: assert property (@(posedge sys_clk) disable iff (reset)
    !control[`BIT_PWIDTH] && any_presc |-> mode == timer_irq_pkg::mode_interval)
    else $error("interval mode not selected");
  AST_MODE_PW: assert property (@(posedge sys_clk) disable iff (reset)
    control[`BIT_PWIDTH] && any_presc |-> pw_mode)
    else $error("pulse width mode not selected");
  AST_MODE_EVENT: assert property (@(posedge sys_clk) disable iff (reset)
    !control[`BIT_PWIDTH] && !any_presc |-> ev_mode)
    else $error("event mode not selected");
  AST_IRQ_LEVEL: assert property (@(posedge sys_clk) disable iff (reset)
    req_latch && control[`BIT_TMR_EN] |=> timer_irq)
    else $error("latched request not shown");
  AST_IRQ_DROP: assert property (@(posedge sys_clk) disable iff (reset)
    !control[`BIT_TMR_EN] |=> !timer_irq)
    else $error("request shown while disabled");
  AST_FORWARD_LATE: assert property (@(posedge sys_clk) disable iff (reset)
    req_latch && $rose(control[`BIT_TMR_EN]) |=> timer_irq)
    else $error("held request not forwarded on enable");
  AST_CLEAR_ACK: assert property (@(posedge sys_clk) disable iff (reset)
    timer_ack && !terminal |=> !req_latch)
    else $error("acknowledge did not clear latch");
  AST_CTRL_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    wr_ctrl |=> control == $past(port_req.data))
    else $error("control write lost");
  AST_CTRL_COPY: assert property (@(posedge sys_clk) disable iff (reset)
    control_out == control)
    else $error("control copy differs");
  AST_READ_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
    !port_req.rd |=> read_data == $past(read_data))
    else $error("read data changed without a read");
  AST_READ_NO_DISTURB: assert property (@(posedge sys_clk) disable iff (reset)
    rd_timer && !tick && !wr_timer |=> count == $past(count))
    else $error("read disturbed the count");
  AST_EV_COUNT: assert property (@(posedge sys_clk) disable iff (reset)
    ev_mode && running && phase && leading |-> tick)
    else $error("event edge not counted");
  AST_NO_TICK_STOPPED: assert property (@(posedge sys_clk) disable iff (reset)
    !running |-> !tick)
    else $error("count step while stopped");
  AST_RESUME: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(running) |-> presc == `PRESC_ZERO)
    else $error("prescaler not zero on restart");
  AST_TERM_ONE: assert property (@(posedge sys_clk) disable iff (reset)
    terminal |-> count == `COUNT_ONE && tick)
    else $error("terminal away from count one");
  AST_MIN_GAP: assert property (@(posedge sys_clk) disable iff (reset)
    terminal && !ev_mode |=> (!terminal || ev_mode) [*3])
    else $error("interval shorter than two phase periods");
  AST_SPAN: assert property (@(posedge sys_clk) disable iff (reset)
    terminal && mode == timer_irq_pkg::mode_interval |-> span <= `SPAN_MAX)
    else $error("interval longer than the maximum span");
endmodule

// ---- hw/timer_irq_map.svh ----
// register offsets, field positions and constants of the timer and interrupt control port
// assumes inclusion by bare name from the design module
`ifndef TIMER_IRQ_MAP_SVH
`define TIMER_IRQ_MAP_SVH
`define PORT_CONTROL 4'h6
`define PORT_TIMER 4'h7
`define BIT_EXT_EN 0
`define BIT_TMR_EN 1
`define BIT_POLARITY 2
`define BIT_RUN 3
`define BIT_PWIDTH 4
`define BIT_DIV2 5
`define BIT_DIV5 6
`define BIT_DIV20 7
`define CTRL_RESET 8'h00
`define TIMER_RESET 8'h00
`define COUNT_ONE 8'h01
`define PRESC_ZERO 8'h00
`define PRESC_ONE 8'h01
`define DIV_2 8'h02
`define DIV_5 8'h05
`define DIV_10 8'h0A
`define DIV_20 8'h14
`define DIV_40 8'h28
`define DIV_100 8'h64
`define DIV_200 8'hC8
`define READ_ZERO_LOW 7'h00
`define SPAN_ZERO 16'h0000
`define SPAN_ONE 16'h0001
`define SPAN_MAX 16'hC800
`endif

// ---- hw/timer_irq_pkg.sv ----
// types shared by the timer and interrupt control port
// assumes the map header is on the include path
package timer_irq_pkg;
  typedef enum logic [1:0] {
    mode_interval,
    mode_pulse_width,
    mode_event
  } timer_mode_e;
  // one port access from the cpu core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] data;
  } port_req_s;
endpackage

// ---- verification/cpu_port_model.sv ----
// cpu core model: port writes, port reads and timer acknowledges
// assumes the timer takes one-cycle strobes on the rising sys_clk edge
`timescale 1ns/1ps
module cpu_port_model (
  // clock
  input wire logic sys_clk,
  // answer from the timer
  input wire logic [7:0] read_data,
  // requests to the timer
  output timer_irq_pkg::port_req_s port_req,
  output logic timer_ack
);
  initial begin
    port_req = '0;
    timer_ack = 1'b0;
  end
  // one port access
  // read data is taken one cycle after the strobe, where it has settled
  task automatic port_io(input logic wr, input logic [3:0] addr, input logic [7:0] data,
                         output logic [7:0] rdat);
    @(posedge sys_clk);
    port_req <= '{wr: wr, rd: !wr, addr: addr, data: data};
    @(posedge sys_clk);
    port_req <= '0;
    #1 rdat = read_data;
  endtask
  // one-cycle acknowledge of the timer request
  task automatic ack_irq;
    @(posedge sys_clk);
    timer_ack <= 1'b1;
    @(posedge sys_clk);
    timer_ack <= 1'b0;
  endtask
endmodule

// ---- verification/timer_irq_control_port_tb.sv ----
// self-checking bench for the timer and interrupt control port
// assumes the cpu model drives all port strobes
`timescale 1ns/1ps
module timer_irq_control_port_tb;
  logic sys_clk, reset, pin, timer_irq;
  logic [7:0] read_data, control_out, rdat, rd_a;
  timer_irq_pkg::port_req_s port_req;
  logic timer_ack;
  int n_errors = 0, checks_done = 0, tick = 0, t0;
  logic [7:0] divs [8] = '{8'h20, 8'h40, 8'h60, 8'h80, 8'hA0, 8'hC0, 8'hE0, 8'h20};
  int facs [8] = '{2, 5, 10, 20, 40, 100, 200, 2};

  timer_irq_control_port uut (.sys_clk(sys_clk), .reset(reset), .port_req(port_req),
    .timer_ack(timer_ack), .external_event_pin(pin), .read_data(read_data),
    .timer_irq(timer_irq), .control_out(control_out));
  cpu_port_model cpu (.sys_clk(sys_clk), .read_data(read_data), .port_req(port_req),
    .timer_ack(timer_ack));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // free cycle count, used to time the gap between requests
  always @(posedge sys_clk) tick <= tick + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cpu.port_io(1'b1, a, d, rd_a);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    cpu.port_io(1'b0, a, 8'h00, d);
  endtask
  // bounded wait, so a lost request cannot hang the run
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 3000 && timer_irq !== lvl; i++) begin
      @(posedge sys_clk);
      #1;
    end
    check(16'(timer_irq), 16'(lvl));
  endtask
  // pulses of 4 cycles active (two phase periods), 5 inactive between pulses and 4 after the last
  task automatic pulse(input logic lvl, input int n);
    repeat (n) begin
      @(posedge sys_clk) pin <= lvl;
      repeat (4) @(posedge sys_clk);
      pin <= ~lvl;
      repeat (4) @(posedge sys_clk);
    end
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    pin = 1'b1;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    rd(4'h7, rdat);
    check(16'(rdat), 16'h0000);
    wr(4'h6, 8'hFF);
    check(16'(control_out), 16'h00FF);
    rd(4'h6, rdat);
    check(16'(rdat), 16'h0080);
    @(posedge sys_clk) pin <= 1'b0;
    rd(4'h6, rdat);
    check(16'(rdat), 16'h0000);
    // request gap for every prescale product, and 256 counts for a zero reload
    for (int k = 0; k < 8; k++) begin
      wr(4'h7, k == 7 ? 8'h00 : 8'h02);
      wr(4'h6, divs[k] | 8'h0A);
      wait_irq(1'b1);
      t0 = tick;
      cpu.ack_irq();
      wait_irq(1'b0);
      wait_irq(1'b1);
      check(16'(tick - t0), 16'((k == 7 ? 256 : 2) * facs[k] * 2));
    end
    // latched request withheld while disabled, shown once enabled
    wr(4'h7, 8'h02);
    wr(4'h6, 8'h28);
    repeat (30) @(posedge sys_clk);
    check(16'(timer_irq), 16'h0000);
    wr(4'h6, 8'h22);
    @(posedge sys_clk) #1;
    check(16'(timer_irq), 16'h0001);
    wr(4'h7, 8'h50);
    @(posedge sys_clk) #1;
    check(16'(timer_irq), 16'h0000);
    // stop freezes the count and reads do not disturb it
    wr(4'h6, 8'h2A);
    repeat (40) @(posedge sys_clk);
    wr(4'h6, 8'h22);
    rd(4'h7, rdat);
    repeat (40) @(posedge sys_clk);
    rd(4'h7, rd_a);
    check(16'(rd_a), 16'(rdat));
    check(16'(rdat inside {[8'h44:8'h47]}), 16'h0001);
    // event counting on rising, then on falling active level
    wr(4'h6, 8'h0C);
    wr(4'h7, 8'h05);
    pulse(1'b1, 3);
    rd(4'h7, rdat);
    check(16'(rdat), 16'h0002);
    @(posedge sys_clk) pin <= 1'b1;
    wr(4'h6, 8'h08);
    wr(4'h7, 8'h05);
    pulse(1'b0, 2);
    rd(4'h7, rdat);
    check(16'(rdat), 16'h0003);
    // pulse width: halted while inactive, about ten counts in 40 cycles
    @(posedge sys_clk) pin <= 1'b0;
    wr(4'h6, 8'h3C);
    wr(4'h7, 8'h10);
    repeat (40) @(posedge sys_clk);
    rd(4'h7, rdat);
    check(16'(rdat), 16'h0010);
    @(posedge sys_clk) pin <= 1'b1;
    repeat (40) @(posedge sys_clk);
    pin <= 1'b0;
    rd(4'h7, rdat);
    check(16'(rdat inside {[8'h05:8'h07]}), 16'h0001);
    report_and_stop();
  end
  // watchdog well beyond the longest expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end
endmodule
